// ===== hw/conv_port_consts.svh
// Timing counts and field constants for the converter serial port and sync/reset pin
// How it works
// - Low for 2048 master periods: full reset
// - Low 1 to 2047 periods: sync only
// - Sync pin sampled on master clock rising
// - Sample-ready high and low four periods each
// - Serial clock idles low, mode one
// - Host moves select only with clock low
// - Device captures input on falling edge
// - Device launches output on rising edge
// - Output driven while selected, else released
// - First sample-ready rise 250 us after power
// - Register defaults load takes 5 us
// - Sync pulse aligns conversions across converters
`ifndef CONV_PORT_CONSTS_SVH
`define CONV_PORT_CONSTS_SVH
`define RESET_LOW_PERIODS 2048
`define SYNC_MAX_PERIODS 2047
`define READY_HALF_PERIODS 4
`define PORT_TIMEOUT_PERIODS 32768
`define CLK_MHZ 50
`define POR_TIME_US 250
`define POR_CYCLES (`POR_TIME_US * `CLK_MHZ)
`define REGACQ_TIME_US 5
`define REGACQ_CYCLES (`REGACQ_TIME_US * `CLK_MHZ)
`define WORD_BITS 24
`define FIFO_DEPTH 16
`define SCLK_HALF_CYCLES 4
`define MCLK_HALF_CYCLES 4
`define FRAME_PERIODS 8
`endif

// ===== hw/conv_port_pkg.sv
// Types shared by both ends of the converter port
package conv_port_pkg;
   typedef enum logic [1:0] {
      DEV_POR = 2'b00,
      DEV_REGLOAD = 2'b01,
      DEV_RUN = 2'b10
   } dev_state_type;
   typedef enum logic [1:0] {
      HOST_IDLE = 2'b00,
      HOST_SETUP = 2'b01,
      HOST_SHIFT = 2'b10,
      HOST_DONE = 2'b11
   } host_state_type;
endpackage : conv_port_pkg

// ===== hw/conv_port_if.sv
// Interface joining the host controller and the converter device
`timescale 1ns/1ps
`default_nettype none
interface conv_port_if;
   logic mclk;
   logic sync_rst_n;
   logic sclk;
   logic cs_n;
   logic din;
   logic dout;
   logic dout_oe;
   logic sample_ready;
   modport device (input mclk, input sync_rst_n, input sclk, input cs_n, input din,
      output dout, output dout_oe, output sample_ready);
   modport host (output mclk, output sync_rst_n, output sclk, output cs_n, output din,
      input dout, input dout_oe, input sample_ready);
endinterface : conv_port_if
`default_nettype wire

// ===== hw/word_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 16
) (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);
   // Pointer wrap relies on a power-of-two depth
   if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_param
      $error("DEPTH must be a power of two");
   end
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0] wr_q;
   logic [AW:0] rd_q;
   logic push;
   logic pop;
   assign o_in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
   assign o_out_valid = wr_q != rd_q;
   assign push = i_in_valid && o_in_ready;
   assign pop = o_out_valid && i_out_ready;
   assign o_out_data = mem_q[rd_q[AW-1:0]];
   always_ff @(posedge i_ref_clk) begin
      if (push) mem_q[wr_q[AW-1:0]] <= i_in_data;
   end
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) wr_q <= wr_q + 1'b1;
         if (pop) rd_q <= rd_q + 1'b1;
      end
   end
endmodule : word_fifo
`default_nettype wire

// ===== hw/conv_device.sv
// Converter end: sync/reset discrimination, sample-ready pulses, mode-1 serial slave
`timescale 1ns/1ps
`default_nettype none
`include "conv_port_consts.svh"
module conv_device
   import conv_port_pkg::*;
#(
   parameter int WIDTH = `WORD_BITS,
   parameter int POR_CYCLES = `POR_CYCLES,
   parameter int TIMEOUT_PERIODS = `PORT_TIMEOUT_PERIODS,
   parameter int FRAME_PERIODS = `FRAME_PERIODS
) (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   conv_port_if.device port,
   input wire logic i_tx_valid,
   output logic o_tx_ready,
   input wire logic [WIDTH-1:0] i_tx_data,
   output logic o_rx_valid,
   output logic [WIDTH-1:0] o_rx_data,
   output logic o_sync_pulse,
   output logic o_dev_reset,
   output logic o_regs_settled
);
   localparam int RC = `REGACQ_CYCLES;
   localparam int BW = $clog2(WIDTH + 1);
   localparam int WW = $clog2(POR_CYCLES + RC + 1);
   // Power-on must outlast the register load; counters are 16 and 6 bits wide
   if (WIDTH < 2 || POR_CYCLES <= RC || TIMEOUT_PERIODS < 2 || TIMEOUT_PERIODS > 65536 ||
         FRAME_PERIODS <= `READY_HALF_PERIODS || FRAME_PERIODS > 64) begin : g_bad_param
      $error("bad parameter");
   end
   // Three-stage samplers for every pin from the other party
   logic [2:0] mclk_s_q, sync_s_q, sclk_s_q, cs_s_q, din_s_q;
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mclk_s_q <= '0;
         sync_s_q <= 3'h7;
         sclk_s_q <= '0;
         cs_s_q <= 3'h7;
         din_s_q <= '0;
      end else begin
         mclk_s_q <= {mclk_s_q[1:0], port.mclk};
         sync_s_q <= {sync_s_q[1:0], port.sync_rst_n};
         sclk_s_q <= {sclk_s_q[1:0], port.sclk};
         cs_s_q <= {cs_s_q[1:0], port.cs_n};
         din_s_q <= {din_s_q[1:0], port.din};
      end
   end
   logic mclk_rise, sclk_rise, sclk_fall, cs_n, sync_n;
   assign mclk_rise = mclk_s_q[1] && !mclk_s_q[2];
   assign sclk_rise = sclk_s_q[1] && !sclk_s_q[2];
   assign sclk_fall = !sclk_s_q[1] && sclk_s_q[2];
   assign cs_n = cs_s_q[2];
   assign sync_n = sync_s_q[2];
   // Low-length measure in master clock periods
   logic [11:0] low_cnt_q;
   logic sync_prev_q;
   logic dev_reset;
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         low_cnt_q <= '0;
         sync_prev_q <= 1'b1;
      end else if (mclk_rise) begin
         sync_prev_q <= sync_n;
         if (sync_n) low_cnt_q <= '0;
         else if (low_cnt_q != 12'(`RESET_LOW_PERIODS)) low_cnt_q <= low_cnt_q + 1'b1;
      end
   end
   assign dev_reset = low_cnt_q == 12'(`RESET_LOW_PERIODS);
   // A short low ends with a rise before the reset count was reached
   logic sync_event;
   assign sync_event = mclk_rise && sync_n && !sync_prev_q &&
      low_cnt_q != '0 && low_cnt_q <= 12'(`SYNC_MAX_PERIODS);
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) o_sync_pulse <= 1'b0;
      else o_sync_pulse <= sync_event;
   end
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) o_dev_reset <= 1'b0;
      else o_dev_reset <= dev_reset;
   end
   // Power-on wait, then register default load
   dev_state_type state_q;
   logic [WW-1:0] wait_q;
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_q <= DEV_POR;
         wait_q <= '0;
      end else if (dev_reset) begin
         state_q <= DEV_REGLOAD;
         wait_q <= '0;
      end else begin
         unique case (state_q)
            DEV_POR: begin
               wait_q <= wait_q + 1'b1;
               if (wait_q == WW'(POR_CYCLES - RC - 1)) begin
                  state_q <= DEV_REGLOAD;
                  wait_q <= '0;
               end
            end
            DEV_REGLOAD: begin
               wait_q <= wait_q + 1'b1;
               if (wait_q == WW'(RC - 1)) state_q <= DEV_RUN;
            end
            DEV_RUN: wait_q <= '0;
            default: state_q <= DEV_POR;
         endcase
      end
   end
   assign o_regs_settled = state_q == DEV_RUN;
   // Sample-ready: high 4, low 4 periods, restarted by sync
   logic [5:0] frame_q;
   logic ready_q;
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         frame_q <= '0;
         ready_q <= 1'b0;
      end else if (state_q != DEV_RUN || sync_event) begin
         // Restart on the same rise as the sync, so a high pulse in progress is cut short
         frame_q <= '0;
         ready_q <= 1'b0;
      end else if (mclk_rise) begin
         frame_q <= (frame_q == 6'(FRAME_PERIODS - 1)) ? '0 : frame_q + 1'b1;
         ready_q <= frame_q < 6'(`READY_HALF_PERIODS);
      end
   end
   assign port.sample_ready = ready_q;
   // Serial slave, mode 1; only reads the host's clock
   logic [WIDTH-1:0] tx_sh_q, rx_sh_q;
   logic [BW-1:0] bit_q;
   logic [15:0] idle_q;
   logic dout_q, oe_q, loaded_q;
   logic fifo_valid;
   logic [WIDTH-1:0] fifo_data;
   word_fifo #(.WIDTH(WIDTH), .DEPTH(`FIFO_DEPTH)) tx_fifo (
      .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
      .i_in_valid(i_tx_valid), .o_in_ready(o_tx_ready), .i_in_data(i_tx_data),
      .o_out_valid(fifo_valid), .i_out_ready(cs_n && !loaded_q),
      .o_out_data(fifo_data));
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tx_sh_q <= '0;
         rx_sh_q <= '0;
         bit_q <= '0;
         idle_q <= '0;
         dout_q <= 1'b0;
         oe_q <= 1'b0;
         loaded_q <= 1'b0;
         o_rx_valid <= 1'b0;
         o_rx_data <= '0;
      end else begin
         o_rx_valid <= 1'b0;
         oe_q <= !cs_n;
         if (cs_n) begin
            bit_q <= '0;
            idle_q <= '0;
            if (fifo_valid && !loaded_q) begin
               tx_sh_q <= fifo_data;
               loaded_q <= 1'b1;
            end
         end else if (sclk_rise) begin
            dout_q <= tx_sh_q[WIDTH-1];
            tx_sh_q <= {tx_sh_q[WIDTH-2:0], 1'b0};
            loaded_q <= 1'b0;
            idle_q <= '0;
         end else if (sclk_fall) begin
            rx_sh_q <= {rx_sh_q[WIDTH-2:0], din_s_q[2]};
            idle_q <= '0;
            if (bit_q == BW'(WIDTH - 1)) begin
               bit_q <= '0;
               o_rx_valid <= 1'b1;
               o_rx_data <= {rx_sh_q[WIDTH-2:0], din_s_q[2]};
            end else bit_q <= bit_q + 1'b1;
         end else if (mclk_rise) begin
            if (idle_q == 16'(TIMEOUT_PERIODS - 1)) begin
               bit_q <= '0;
               idle_q <= '0;
            end else if (bit_q != '0) idle_q <= idle_q + 1'b1;
         end
      end
   end
   assign port.dout = dout_q;
   assign port.dout_oe = oe_q;
endmodule : conv_device
`default_nettype wire

// ===== hw/conv_host.sv
// Host end: mode-1 serial controller, master clock and sync/reset driver
`timescale 1ns/1ps
`default_nettype none
`include "conv_port_consts.svh"
module conv_host
   import conv_port_pkg::*;
#(
   parameter int WIDTH = `WORD_BITS
) (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   conv_port_if.host port,
   input wire logic i_cmd_valid,
   output logic o_cmd_ready,
   input wire logic [WIDTH-1:0] i_cmd_data,
   output logic o_rsp_valid,
   output logic [WIDTH-1:0] o_rsp_data,
   input wire logic i_sync_req,
   input wire logic [11:0] i_sync_len,
   output logic o_sync_busy,
   output logic o_ready_seen
);
   localparam int BW = $clog2(WIDTH + 1);
   if (WIDTH < 2) begin : g_bad_param
      $error("bad WIDTH");
   end
   // Master clock from a divider
   logic [2:0] mdiv_q;
   logic mclk_q, mclk_fall;
   assign mclk_fall = mclk_q && mdiv_q == 3'(`MCLK_HALF_CYCLES - 1);
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mdiv_q <= '0;
         mclk_q <= 1'b0;
      end else if (mdiv_q == 3'(`MCLK_HALF_CYCLES - 1)) begin
         mdiv_q <= '0;
         mclk_q <= !mclk_q;
      end else mdiv_q <= mdiv_q + 1'b1;
   end
   assign port.mclk = mclk_q;
   // Sync/reset low for a counted number of periods, changed at falling edge
   logic [11:0] slen_q;
   logic sync_n_q;
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         slen_q <= '0;
         sync_n_q <= 1'b1;
      end else if (sync_n_q && i_sync_req && i_sync_len != '0) begin
         slen_q <= i_sync_len;
      end else if (mclk_fall) begin
         if (slen_q != '0) begin
            sync_n_q <= 1'b0;
            slen_q <= slen_q - 1'b1;
         end else sync_n_q <= 1'b1;
      end
   end
   assign port.sync_rst_n = sync_n_q;
   assign o_sync_busy = slen_q != '0 || !sync_n_q;
   // Sample-ready seen, through three stages
   logic [2:0] rdy_s_q, dout_s_q;
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rdy_s_q <= '0;
         dout_s_q <= '0;
         o_ready_seen <= 1'b0;
      end else begin
         rdy_s_q <= {rdy_s_q[1:0], port.sample_ready};
         dout_s_q <= {dout_s_q[1:0], port.dout};
         if (rdy_s_q[1] && !rdy_s_q[2]) o_ready_seen <= 1'b1;
      end
   end
   // Serial controller
   host_state_type st_q;
   logic [1:0] sdiv_q;
   logic sclk_q, din_q;
   logic cs_n_q;
   logic [BW-1:0] bit_q;
   logic [WIDTH-1:0] tx_q, rx_q;
   logic tick;
   assign tick = sdiv_q == 2'(`SCLK_HALF_CYCLES - 1);
   assign o_cmd_ready = st_q == HOST_IDLE;
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_q <= HOST_IDLE;
         sdiv_q <= '0;
         sclk_q <= 1'b0;
         cs_n_q <= 1'b1;
         din_q <= 1'b0;
         bit_q <= '0;
         tx_q <= '0;
         rx_q <= '0;
         o_rsp_valid <= 1'b0;
         o_rsp_data <= '0;
      end else begin
         o_rsp_valid <= 1'b0;
         sdiv_q <= tick ? '0 : sdiv_q + 1'b1;
         unique case (st_q)
            HOST_IDLE: if (i_cmd_valid) begin
               tx_q <= i_cmd_data;
               cs_n_q <= 1'b0;
               bit_q <= '0;
               sdiv_q <= '0;
               st_q <= HOST_SETUP;
            end
            HOST_SETUP: if (tick) begin
               sclk_q <= 1'b1;
               din_q <= tx_q[WIDTH-1];
               tx_q <= {tx_q[WIDTH-2:0], 1'b0};
               st_q <= HOST_SHIFT;
            end
            HOST_SHIFT: if (tick) begin
               if (sclk_q) begin
                  sclk_q <= 1'b0;
               end else begin
                  rx_q <= {rx_q[WIDTH-2:0], dout_s_q[2]};
                  if (bit_q == BW'(WIDTH - 1)) st_q <= HOST_DONE;
                  else begin
                     bit_q <= bit_q + 1'b1;
                     sclk_q <= 1'b1;
                     din_q <= tx_q[WIDTH-1];
                     tx_q <= {tx_q[WIDTH-2:0], 1'b0};
                  end
               end
            end
            HOST_DONE: if (tick) begin
               cs_n_q <= 1'b1;
               o_rsp_valid <= 1'b1;
               o_rsp_data <= rx_q;
               st_q <= HOST_IDLE;
            end
         endcase
      end
   end
   // Input bit set half a period before the device's falling-edge capture
   assign port.din = din_q;
   assign port.sclk = sclk_q;
   assign port.cs_n = cs_n_q;
endmodule : conv_host
`default_nettype wire

// ===== sim/conv_port_props.sv
// Concurrent checks on the wires between host and converter ends
`timescale 1ns/1ps
`default_nettype none
module conv_port_props #(
   parameter int POR_CYCLES = 400
) (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic mclk,
   input wire logic sync_rst_n,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   input wire logic dout,
   input wire logic dout_oe,
   input wire logic sample_ready
);
   logic [15:0] por_cnt_q;
   logic [7:0] hi_cnt_q;
   logic [7:0] lo_cnt_q;
   logic [7:0] sq_cnt_q;
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rst_n);
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) por_cnt_q <= '0;
      else if (por_cnt_q < 16'(POR_CYCLES)) por_cnt_q <= por_cnt_q + 16'h0001;
   end
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) hi_cnt_q <= '0;
      else if (sample_ready) hi_cnt_q <= hi_cnt_q + 8'h01;
      else hi_cnt_q <= '0;
   end
   // A sync release cuts or stretches the pulse around it, so those few are skipped
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) sq_cnt_q <= '0;
      else if (!sync_rst_n) sq_cnt_q <= '0;
      else if (sq_cnt_q != 8'hff) sq_cnt_q <= sq_cnt_q + 8'h01;
   end
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) lo_cnt_q <= '0;
      else if (sample_ready) lo_cnt_q <= '0;
      else if (lo_cnt_q != 8'hff) lo_cnt_q <= lo_cnt_q + 8'h01;
   end
   sequence sclk_high_half;
      sclk [*4] ##1 !sclk;
   endsequence
   a_cs_moves_low: assert property ($changed(cs_n) |-> !sclk && !$past(sclk))
      else $error("select moved while serial clock high");
   a_sclk_idle_low: assert property (cs_n |-> !sclk)
      else $error("serial clock not low while idle");
   a_sclk_half: assert property ($rose(sclk) |-> sclk_high_half)
      else $error("serial clock high phase wrong length");
   a_din_stable_fall: assert property ($fell(sclk) |-> $stable(din))
      else $error("host data moved at capture edge");
   a_dout_launch_rise: assert property ($fell(sclk) && !cs_n |-> $stable(dout))
      else $error("device data moved at falling edge");
   a_oe_on_select: assert property ($fell(cs_n) |-> ##[0:5] dout_oe)
      else $error("device output not driven after select");
   a_oe_off_release: assert property ($rose(cs_n) |-> ##[0:5] !dout_oe)
      else $error("device output not released");
   a_sync_at_rise: assert property ($rose(mclk) |-> $stable(sync_rst_n))
      else $error("sync pin moved at master clock rise");
   a_ready_high_len: assert property ($fell(sample_ready) && sq_cnt_q > 8'h0c |->
      hi_cnt_q == 8'h20)
      else $error("sample ready high pulse not four periods");
   a_ready_low_len: assert property ($rose(sample_ready) && sq_cnt_q > 8'h18 &&
      lo_cnt_q != 8'hff |-> lo_cnt_q == 8'h20)
      else $error("sample ready low pulse not four periods");
   a_por_quiet: assert property (por_cnt_q < 16'(POR_CYCLES) |-> !sample_ready)
      else $error("sample ready rose before power-on time");
endmodule : conv_port_props
`default_nettype wire

// ===== sim/tb.sv
// Testbench joining host and converter ends across the port interface
`timescale 1ns/1ps
`default_nettype none
module tb;
   import conv_port_pkg::*;
   localparam int W = 24;
   logic i_ref_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic cmd_valid = 1'b0, tx_valid = 1'b0, sync_req = 1'b0;
   logic [W-1:0] cmd_data = '0, tx_data = '0;
   logic [11:0] sync_len = 12'h000;
   logic cmd_ready, rsp_valid, sync_busy, ready_seen, tx_ready, rx_valid;
   logic sync_pulse, dev_reset, regs_settled, reset_prev;
   logic [W-1:0] rsp_data, rx_data;
   logic [W-1:0] exp_rx[$], exp_rsp[$];
   int mismatches = 0;
   int samples_checked = 0;
   int sync_count = 0, reset_count = 0, n, c0, r0;
   int seed = 32'h4987_0555;
   int lens[3] = '{1, 2047, 2048};
   conv_port_if port_if();
   conv_host #(.WIDTH(W)) conv_host_inst (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
      .port(port_if.host), .i_cmd_valid(cmd_valid), .o_cmd_ready(cmd_ready),
      .i_cmd_data(cmd_data), .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data),
      .i_sync_req(sync_req), .i_sync_len(sync_len), .o_sync_busy(sync_busy),
      .o_ready_seen(ready_seen));
   // Short power-on and timeout counts keep the run brief
   conv_device #(.WIDTH(W), .POR_CYCLES(400), .TIMEOUT_PERIODS(64)) conv_device_inst (
      .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .port(port_if.device),
      .i_tx_valid(tx_valid), .o_tx_ready(tx_ready), .i_tx_data(tx_data),
      .o_rx_valid(rx_valid), .o_rx_data(rx_data), .o_sync_pulse(sync_pulse),
      .o_dev_reset(dev_reset), .o_regs_settled(regs_settled));
   conv_port_props #(.POR_CYCLES(400)) conv_port_props_inst (.i_ref_clk(i_ref_clk),
      .i_rst_n(i_rst_n), .mclk(port_if.mclk), .sync_rst_n(port_if.sync_rst_n),
      .sclk(port_if.sclk), .cs_n(port_if.cs_n), .din(port_if.din), .dout(port_if.dout),
      .dout_oe(port_if.dout_oe), .sample_ready(port_if.sample_ready));
   always #10 i_ref_clk = ~i_ref_clk;
   task automatic check(input logic [W-1:0] seen, input logic [W-1:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic finish_test();
      $display("Counts: %0d checked, %0d mismatches", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : finish_test
   task automatic wait_until(input int sel, input int lim);
      int k;
      k = 0;
      while (!(sel == 0 ? ready_seen === 1'b1 : sel == 1 ? regs_settled === 1'b1 :
            sel == 2 ? sync_busy === 1'b0 : sel == 3 ? cmd_ready === 1'b1 :
            exp_rsp.size() == 0)) begin
         @(negedge i_ref_clk);
         k++;
         if (k > lim) begin
            mismatches++;
            $display("MISMATCH t=%0t wait %0d ran out", $time, sel);
            finish_test();
         end
      end
   endtask : wait_until
   // Results are matched against the oldest expectation as they appear
   always @(posedge i_ref_clk) begin
      if (rx_valid === 1'b1) check(rx_data, exp_rx.size() ? exp_rx.pop_front() : 'x);
      if (rsp_valid === 1'b1) check(rsp_data, exp_rsp.size() ? exp_rsp.pop_front() : 'x);
      if (sync_pulse === 1'b1) sync_count++;
      if (dev_reset === 1'b1 && reset_prev !== 1'b1) reset_count++;
      reset_prev = dev_reset;
   end
   initial begin
      repeat (12) @(negedge i_ref_clk);
      i_rst_n = 1'b1;
      wait_until(0, 2000);
      wait_until(1, 2000);
      $display("test power-on done");
      n = 0;
      tx_valid = 1'b1;
      while (tx_ready === 1'b1 && n < 20) begin
         tx_data = W'($random(seed));
         exp_rsp.push_back(tx_data);
         n++;
         @(negedge i_ref_clk);
      end
      tx_valid = 1'b0;
      // One word may already sit in the shifter, beside a full buffer
      check(W'(n >= 16 && n <= 17), W'(1));
      $display("test buffer fill done");
      for (int i = 0; i < n; i++) begin
         wait_until(3, 500);
         cmd_valid = 1'b1;
         cmd_data = W'($random(seed));
         exp_rx.push_back(cmd_data);
         @(negedge i_ref_clk);
         cmd_valid = 1'b0;
      end
      wait_until(4, 1000);
      repeat (20) @(negedge i_ref_clk);
      check(W'(exp_rx.size()), W'(0));
      $display("test frames done");
      foreach (lens[k]) begin
         c0 = sync_count;
         r0 = reset_count;
         sync_len = 12'(lens[k]);
         sync_req = 1'b1;
         @(negedge i_ref_clk);
         sync_req = 1'b0;
         wait_until(2, 20000);
         repeat (60) @(negedge i_ref_clk);
         check(W'(sync_count - c0), W'(lens[k] < 2048));
         check(W'(reset_count - r0), W'(lens[k] >= 2048));
         wait_until(1, 2000);
         $display("test sync length %0d done", lens[k]);
      end
      finish_test();
   end
endmodule : tb
`default_nettype wire
